/* File: fesc_defs.vh */
`ifndef FESC_DEFS_VH
`define FESC_DEFS_VH
// Command bytes and unlock addresses.
`define FESC_CMD_UNLOCK1 8'hAA
`define FESC_CMD_UNLOCK2 8'h55
`define FESC_ADDR_UNLOCK1 12'h555
`define FESC_ADDR_UNLOCK2 12'hAAA
`define FESC_CMD_ERASE_SETUP 8'h80
`define FESC_CMD_BULK 8'h10
`define FESC_CMD_SECTOR 8'h30
`define FESC_CMD_SUSPEND 8'hB0
`define FESC_CMD_RESUME 8'h30
`define FESC_CMD_RESET 8'hF0
// Status bit positions in the polled data byte.
`define FESC_BIT_POLL 7
`define FESC_BIT_TOGGLE 6
`define FESC_BIT_ERROR 5
`define FESC_BIT_WINDOW 3
// Timing in ns and derived 100 MHz cycle counts.
`define FESC_CLK_NS 10
`define FESC_WINDOW_NS 100000
`define FESC_WINDOW_CYC (`FESC_WINDOW_NS / `FESC_CLK_NS)
`define FESC_SUSP_NS 1000
`define FESC_SUSP_CYC (`FESC_SUSP_NS / `FESC_CLK_NS)
`define FESC_RECOVER_NS 25000
`define FESC_RECOVER_CYC (`FESC_RECOVER_NS / `FESC_CLK_NS)
`define FESC_PHASE_CYC 20000
`define FESC_MAX_PULSES 4
`endif

/* File: fesc_sequencer.v */
`timescale 1ns/1ns
`include "fesc_defs.vh"
module fesc_sequencer #(
	parameter WINDOW_CYC = `FESC_WINDOW_CYC,
	parameter PHASE_CYC = `FESC_PHASE_CYC,
	parameter RECOVER_CYC = `FESC_RECOVER_CYC,
	parameter SUSP_CYC = `FESC_SUSP_CYC,
	parameter MAX_PULSES = `FESC_MAX_PULSES,
	parameter NSEC = 12
)(
	input wire clock_i,
	input wire rst_i,
	input wire reset_pin_i,
	input wire wr_i,
	input wire rd_i,
	input wire [11:0] addr_i,
	input wire [7:0] wdata_i,
	input wire [7:0] main_sector_selects_i,
	input wire [3:0] boot_sector_selects_i,
	input wire lock_rd_main_i,
	input wire lock_rd_boot_i,
	input wire [7:0] main_lock_i,
	input wire [3:0] boot_lock_i,
	input wire secure_i,
	input wire erase_fail_i,
	output reg [7:0] status_o,
	output reg status_valid_o,
	output reg array_data_valid_o,
	output reg [7:0] lock_status_o,
	output reg busy_o,
	output reg [NSEC-1:0] erase_sectors_o,
	output reg [NSEC-1:0] invalid_sectors_o,
	output reg write_zero_o,
	output reg write_ones_o
);
	localparam S_READ = 3'd0;
	localparam S_WINDOW = 3'd1;
	localparam S_SECTOR = 3'd2;
	localparam S_BULK = 3'd3;
	localparam S_SUSPENDING = 3'd4;
	localparam S_SUSPENDED = 3'd5;
	localparam S_RECOVER = 3'd6;
	localparam S_ERROR = 3'd7;

	reg [2:0] state;
	reg [2:0] step;
	reg [31:0] cnt;
	reg phase_ones;
	reg [7:0] pulses;
	reg window_flag;
	reg toggle;
	reg error_flag;
	reg [NSEC-1:0] targets;
	reg [NSEC-1:0] invalid;
	wire [NSEC-1:0] sel;
	wire [NSEC-1:0] locks;
	wire sel_any;
	wire hit_target;
	wire is_reset_cmd;

	assign sel = {boot_sector_selects_i, main_sector_selects_i};
	assign locks = {boot_lock_i, main_lock_i};
	assign sel_any = |sel;
	assign hit_target = |(sel & targets);

	// A reset command needs no address match; the unlock pair is optional.
	function is_unlock;
		input [2:0] s;
		input [11:0] a;
		input [7:0] d;
		begin
			is_unlock = (s == 3'd0 && a == `FESC_ADDR_UNLOCK1 &&
				d == `FESC_CMD_UNLOCK1) ||
				(s == 3'd1 && a == `FESC_ADDR_UNLOCK2 &&
				d == `FESC_CMD_UNLOCK2) ||
				(s == 3'd3 && a == `FESC_ADDR_UNLOCK1 &&
				d == `FESC_CMD_UNLOCK1) ||
				(s == 3'd4 && a == `FESC_ADDR_UNLOCK2 &&
				d == `FESC_CMD_UNLOCK2);
		end
	endfunction

	assign is_reset_cmd = wdata_i == `FESC_CMD_RESET;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= S_READ;
			step <= 3'd0;
			cnt <= 32'h0000_0000;
			phase_ones <= 1'b0;
			pulses <= 8'h00;
			window_flag <= 1'b0;
			error_flag <= 1'b0;
			targets <= {NSEC{1'b0}};
			invalid <= {NSEC{1'b0}};
		end
		else if (reset_pin_i)
		begin
			// Pin pulse aborts everything; the array needs time to settle.
			state <= S_RECOVER;
			step <= 3'd0;
			cnt <= RECOVER_CYC;
			window_flag <= 1'b0;
			error_flag <= 1'b0;
			if (state == S_SECTOR || state == S_SUSPENDED ||
				state == S_SUSPENDING || state == S_BULK)
				invalid <= invalid | targets;
			targets <= {NSEC{1'b0}};
		end
		else
		begin
			case (state)
			S_READ:
			begin
				if (wr_i)
				begin
					if (is_unlock(step, addr_i, wdata_i))
						step <= step + 3'd1;
					else if (step == 3'd2 &&
						wdata_i == `FESC_CMD_ERASE_SETUP)
						step <= 3'd3;
					else if (step == 3'd5 &&
						wdata_i == `FESC_CMD_BULK)
					begin
						step <= 3'd0;
						targets <= ~locks;
						if (|(~locks))
						begin
							state <= S_BULK;
							// Bulk erase has no window, so it reads as erasing.
							window_flag <= 1'b1;
							cnt <= PHASE_CYC;
							phase_ones <= 1'b0;
							pulses <= 8'h00;
						end
					end
					else if (step == 3'd5 &&
						wdata_i == `FESC_CMD_SECTOR && sel_any)
					begin
						step <= 3'd0;
						targets <= sel & ~locks;
						state <= S_WINDOW;
						cnt <= WINDOW_CYC;
						window_flag <= 1'b0;
					end
					else
						step <= 3'd0;
				end
			end
			S_WINDOW:
			begin
				if (wr_i)
				begin
					if (wdata_i == `FESC_CMD_SECTOR && sel_any)
					begin
						targets <= targets | (sel & ~locks);
						cnt <= WINDOW_CYC;
					end
					else if (wdata_i == `FESC_CMD_SUSPEND && sel_any)
					begin
						// Window closes; no more sectors may join.
						window_flag <= 1'b1;
						phase_ones <= 1'b0;
						pulses <= 8'h00;
						state <= S_SUSPENDING;
						cnt <= SUSP_CYC;
					end
					else
					begin
						state <= S_READ;
						targets <= {NSEC{1'b0}};
					end
				end
				else if (cnt <= 32'd1)
				begin
					window_flag <= 1'b1;
					phase_ones <= 1'b0;
					pulses <= 8'h00;
					cnt <= PHASE_CYC;
					// All targets locked: nothing to do, back to read.
					state <= (|targets) ? S_SECTOR : S_READ;
				end
				else
					cnt <= cnt - 32'd1;
			end
			S_SECTOR, S_BULK:
			begin
				if (wr_i && state == S_SECTOR && sel_any &&
					wdata_i == `FESC_CMD_SUSPEND)
				begin
					state <= S_SUSPENDING;
					cnt <= SUSP_CYC;
				end
				else if (wr_i && state == S_SECTOR && is_reset_cmd)
				begin
					invalid <= invalid | targets;
					targets <= {NSEC{1'b0}};
					window_flag <= 1'b0;
					state <= S_RECOVER;
					cnt <= RECOVER_CYC;
				end
				else if (cnt <= 32'd1)
				begin
					if (!phase_ones)
					begin
						phase_ones <= 1'b1;
						cnt <= PHASE_CYC;
					end
					else if (!erase_fail_i)
					begin
						state <= S_READ;
						targets <= {NSEC{1'b0}};
						invalid <= invalid & ~targets;
						window_flag <= 1'b0;
					end
					else if (pulses + 8'd1 >= MAX_PULSES)
					begin
						error_flag <= 1'b1;
						state <= S_ERROR;
					end
					else
					begin
						pulses <= pulses + 8'd1;
						cnt <= PHASE_CYC;
					end
				end
				else
					cnt <= cnt - 32'd1;
			end
			S_SUSPENDING:
			begin
				if (cnt <= 32'd1)
					state <= S_SUSPENDED;
				else
					cnt <= cnt - 32'd1;
			end
			S_SUSPENDED:
			begin
				if (wr_i && sel_any && wdata_i == `FESC_CMD_RESUME)
				begin
					state <= S_SECTOR;
					cnt <= PHASE_CYC;
				end
				else if (wr_i && is_reset_cmd)
				begin
					invalid <= invalid | targets;
					targets <= {NSEC{1'b0}};
					window_flag <= 1'b0;
					state <= S_RECOVER;
					cnt <= RECOVER_CYC;
				end
			end
			S_RECOVER:
			begin
				if (cnt <= 32'd1)
					state <= S_READ;
				else
					cnt <= cnt - 32'd1;
			end
			S_ERROR:
			begin
				if (wr_i && is_reset_cmd)
				begin
					error_flag <= 1'b0;
					invalid <= invalid | targets;
					targets <= {NSEC{1'b0}};
					window_flag <= 1'b0;
					state <= S_RECOVER;
					cnt <= RECOVER_CYC;
				end
			end
			default:
				state <= S_READ;
			endcase
		end
	end

	// Status byte and read-path qualifiers, registered for clean outputs.
	wire embedded_busy;
	assign embedded_busy = state == S_BULK || state == S_SECTOR ||
		state == S_WINDOW || state == S_SUSPENDING;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			toggle <= 1'b0;
			status_o <= 8'h00;
			status_valid_o <= 1'b0;
			array_data_valid_o <= 1'b0;
			lock_status_o <= 8'h00;
			busy_o <= 1'b0;
			erase_sectors_o <= {NSEC{1'b0}};
			invalid_sectors_o <= {NSEC{1'b0}};
			write_zero_o <= 1'b0;
			write_ones_o <= 1'b0;
		end
		else
		begin
			if (rd_i && embedded_busy && hit_target)
				toggle <= ~toggle;
			status_o <= 8'h00;
			status_o[`FESC_BIT_POLL] <= 1'b0;
			status_o[`FESC_BIT_TOGGLE] <= toggle;
			status_o[`FESC_BIT_ERROR] <= error_flag;
			status_o[`FESC_BIT_WINDOW] <= window_flag;
			status_valid_o <= (embedded_busy || state == S_ERROR) &&
				hit_target;
			array_data_valid_o <= !hit_target &&
				(state == S_READ || state == S_SUSPENDED ||
				embedded_busy);
			// Lock bits come from straps; host writes have no path here.
			if (lock_rd_main_i)
				lock_status_o <= main_lock_i;
			else if (lock_rd_boot_i)
				lock_status_o <= {secure_i, 3'b000, boot_lock_i};
			else
				lock_status_o <= 8'h00;
			busy_o <= state != S_READ && state != S_SUSPENDED;
			erase_sectors_o <= targets;
			invalid_sectors_o <= invalid;
			write_zero_o <= (state == S_BULK || state == S_SECTOR) &&
				!phase_ones;
			write_ones_o <= (state == S_BULK || state == S_SECTOR) &&
				phase_ones;
		end
	end
endmodule

/* File: fesc_chk.sv */
`timescale 1ns/1ns
module fesc_chk #(
	parameter NSEC = 12
)(
	input wire clock_i,
	input wire rst_i,
	input wire reset_pin_i,
	input wire [7:0] main_lock_i,
	input wire [3:0] boot_lock_i,
	input wire erase_fail_i,
	input wire [7:0] status_o,
	input wire status_valid_o,
	input wire busy_o,
	input wire [NSEC-1:0] erase_sectors_o,
	input wire write_zero_o,
	input wire write_ones_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	chk_lock_skip:
	assert property ((erase_sectors_o & {boot_lock_i, main_lock_i}) == 0)
		else $error("locked sector targeted");
	chk_poll_low:
	assert property (status_valid_o |-> !status_o[7])
		else $error("poll bit high");
	chk_window_set:
	assert property (write_ones_o |-> status_o[3] && busy_o)
		else $error("window flag low in erase");
	chk_phase_excl:
	assert property (!(write_zero_o && write_ones_o))
		else $error("phases overlap");
	chk_err_cause:
	assert property ($rose(status_o[5]) |->
		$past(erase_fail_i) || $past(erase_fail_i, 2))
		else $error("error without fail");
	chk_pin_abort:
	assert property (reset_pin_i |=> ##1 !write_zero_o && !write_ones_o)
		else $error("pin did not abort");
	chk_pin_error:
	assert property (reset_pin_i |=> ##1 !status_o[5])
		else $error("pin left error set");
	chk_pin_recover:
	assert property ($fell(reset_pin_i) |-> ##[1:12] !busy_o)
		else $error("no recovery");
endmodule
bind fesc_sequencer fesc_chk #(.NSEC(NSEC)) i_fesc_chk (
	.clock_i(clock_i), .rst_i(rst_i), .reset_pin_i(reset_pin_i),
	.main_lock_i(main_lock_i), .boot_lock_i(boot_lock_i),
	.erase_fail_i(erase_fail_i), .status_o(status_o),
	.status_valid_o(status_valid_o), .busy_o(busy_o),
	.erase_sectors_o(erase_sectors_o), .write_zero_o(write_zero_o),
	.write_ones_o(write_ones_o));

/* File: fesc_host.sv */
`timescale 1ns/1ns
`include "fesc_defs.vh"
module fesc_host (
	input wire clock_i,
	output logic wr_o,
	output logic rd_o,
	output logic [11:0] addr_o,
	output logic [7:0] wdata_o
);
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 12'h0000;
		wdata_o = 8'h00;
	end
	task automatic put(input logic [11:0] a, input logic [7:0] d);
	begin
		@(negedge clock_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clock_i);
		wr_o = 1'b0;
		// A released bus must not keep the last value.
		addr_o = ~a;
		wdata_o = ~d;
	end
	endtask
	task automatic get;
	begin
		@(negedge clock_i);
		rd_o = 1'b1;
		@(negedge clock_i);
		rd_o = 1'b0;
	end
	endtask
	task automatic unlock;
	begin
		put(`FESC_ADDR_UNLOCK1, `FESC_CMD_UNLOCK1);
		put(`FESC_ADDR_UNLOCK2, `FESC_CMD_UNLOCK2);
	end
	endtask
	task automatic seq(input logic [7:0] c);
	begin
		unlock;
		put(`FESC_ADDR_UNLOCK1, `FESC_CMD_ERASE_SETUP);
		unlock;
		put(`FESC_ADDR_UNLOCK1, c);
	end
	endtask
endmodule

/* File: fesc_sequencer_test.sv */
`timescale 1ns/1ns
module fesc_sequencer_test;
	logic clock_i, rst_i, pin, fail, wr, rd, sv, dv, busy, wz, wo;
	logic sec, t1;
	logic [7:0] msel, st, lk, wd, mlk;
	logic [11:0] addr, es, inv;
	logic [3:0] bsel, blk;
	logic lrm = 1'b0;
	logic lrb = 1'b0;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	fesc_host i_fesc_host (.clock_i(clock_i), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wd));
	fesc_sequencer #(.WINDOW_CYC(20), .PHASE_CYC(8), .RECOVER_CYC(5),
		.SUSP_CYC(3)) i_fesc_sequencer (.clock_i(clock_i), .rst_i(rst_i),
		.reset_pin_i(pin), .wr_i(wr), .rd_i(rd), .addr_i(addr),
		.wdata_i(wd), .main_sector_selects_i(msel),
		.boot_sector_selects_i(bsel), .lock_rd_main_i(lrm),
		.lock_rd_boot_i(lrb), .main_lock_i(mlk), .boot_lock_i(blk),
		.secure_i(sec), .erase_fail_i(fail), .status_o(st),
		.status_valid_o(sv), .array_data_valid_o(dv),
		.lock_status_o(lk), .busy_o(busy), .erase_sectors_o(es),
		.invalid_sectors_o(inv), .write_zero_o(wz), .write_ones_o(wo));
	task automatic chk(input string n, input logic [11:0] e,
		input logic [11:0] g);
	begin
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic idle(input int n);
		while (busy !== 1'b0 && n-- > 0) @(negedge clock_i);
	endtask
	task automatic tally_and_finish;
	begin
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// The whole run needs well under a thousand cycles.
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			tally_and_finish;
		end
	end
	initial
	begin
		rst_i = 1'b1;
		pin = 1'b0;
		fail = 1'b0;
		msel = 8'h00;
		bsel = 4'h0;
		mlk = 8'h5A;
		blk = 4'h3;
		sec = 1'b1;
		t1 = 1'b0;
		tick(5);
		rst_i = 1'b0;
		lrm = 1'b1;
		tick(1);
		chk("main lock", 12'h005A, {4'h0, lk});
		lrm = 1'b0;
		lrb = 1'b1;
		tick(1);
		chk("boot lock", 12'h0083, {4'h0, lk});
		mlk = 8'hC3;
		blk = 4'hA;
		sec = 1'b0;
		tick(1);
		chk("boot lock 2", 12'h000A, {4'h0, lk});
		lrb = 1'b0;
		lrm = 1'b1;
		tick(1);
		chk("main lock 2", 12'h00C3, {4'h0, lk});
		lrm = 1'b0;
		mlk = 8'h5A;
		blk = 4'h3;
		sec = 1'b1;
		tick(1);
		chk("no lock read", 12'h0000, {4'h0, lk});
		$display("Locks done");
		i_fesc_host.seq(8'h12);
		tick(2);
		chk("bad bulk", 12'h0000, {11'h0, busy});
		i_fesc_host.seq(8'h10);
		tick(2);
		chk("bulk", 12'h0001, {11'h0, busy});
		chk("bulk set", 12'h0CA5, es);
		i_fesc_host.put(12'h0000, 8'hF0);
		tick(2);
		chk("bulk deaf", 12'h0001, {11'h0, busy});
		idle(200);
		chk("bulk end", 12'h0000, {11'h0, busy});
		$display("Bulk done");
		msel = 8'h01;
		i_fesc_host.seq(8'h30);
		tick(2);
		chk("window", 12'h0000, {11'h0, st[3]});
		i_fesc_host.put(12'h0000, 8'h55);
		tick(2);
		chk("abort", 12'h0000, {11'h0, busy});
		i_fesc_host.seq(8'h30);
		tick(8);
		msel = 8'h04;
		i_fesc_host.put(12'h0000, 8'h30);
		msel = 8'h01;
		tick(14);
		chk("restart", 12'h0000, {11'h0, st[3]});
		i_fesc_host.put(12'h0000, 8'hB0);
		tick(6);
		chk("suspend", 12'h0000, {11'h0, busy});
		i_fesc_host.get;
		chk("held sector", 12'h0000, {11'h0, dv});
		msel = 8'h00;
		bsel = 4'h1;
		i_fesc_host.get;
		chk("other sector", 12'h0001, {11'h0, dv});
		i_fesc_host.put(12'h0555, 8'hAA);
		tick(2);
		chk("no program", 12'h0000, {11'h0, busy});
		msel = 8'h01;
		bsel = 4'h0;
		i_fesc_host.put(12'h0000, 8'h30);
		tick(2);
		chk("resume", 12'h0001, {11'h0, busy});
		chk("closed", 12'h0001, {11'h0, st[3]});
		i_fesc_host.put(12'h0555, 8'hAA);
		tick(2);
		chk("erase deaf", 12'h0001, {11'h0, busy});
		i_fesc_host.put(12'h0000, 8'hB0);
		tick(6);
		i_fesc_host.put(12'h0000, 8'hF0);
		tick(2);
		idle(20);
		chk("invalid", 12'h0005, inv);
		$display("Sector done");
		fail = 1'b1;
		i_fesc_host.seq(8'h30);
		tick(100);
		chk("error", 12'h0001, {11'h0, st[5]});
		chk("status valid", 12'h0001, {11'h0, sv});
		fail = 1'b0;
		i_fesc_host.unlock;
		i_fesc_host.put(12'h0000, 8'hF0);
		tick(2);
		idle(20);
		chk("error clear", 12'h0000, {11'h0, st[5]});
		i_fesc_host.seq(8'h30);
		tick(30);
		i_fesc_host.put(12'h0000, 8'hF0);
		idle(20);
		chk("reset abort", 12'h0000, {11'h0, busy});
		chk("reset abort inv", 12'h0005, inv);
		$display("Error done");
		i_fesc_host.seq(8'h10);
		i_fesc_host.get;
		tick(1);
		t1 = st[6];
		i_fesc_host.get;
		tick(1);
		chk("toggle", {11'h0, ~t1}, {11'h0, st[6]});
		tick(3);
		pin = 1'b1;
		tick(3);
		pin = 1'b0;
		idle(20);
		chk("pin", 12'h0000, {10'h0, busy, wz | wo});
		i_fesc_host.get;
		tick(1);
		t1 = st[6];
		i_fesc_host.get;
		tick(1);
		chk("toggle stop", {11'h0, t1}, {11'h0, st[6]});
		$display("Pin done");
		tally_and_finish;
	end
endmodule
